// file: pc_core_timing.sv
// instruction timing decoder and sequencer with debug halt/step control
`timescale 1ns/1ns
`include "pc_defs.svh"
module pc_core_timing (
   input wire logic clk_in,
   input wire logic nrst_in,
   input wire logic issue_valid_in,
   input wire pc_pkg::pc_issue_t issue_in,
   input wire logic prefetch_enable_in,
   input wire logic [1:0] flash_read_timing_in,
   input wire logic flash_write_en_in,
   input wire logic flash_erase_en_in,
   input wire logic dbg_halt_in,
   input wire logic dbg_run_in,
   input wire logic dbg_step_in,
   input wire logic bp_enable_in,
   input wire logic [15:0] bp_addr_in,
   output logic ready_out,
   output pc_pkg::pc_retire_t retire_out,
   output pc_pkg::pc_flash_t flash_out,
   output logic halted_out
);

   // full opcode map; operand ram (256 bytes) lives in the datapath
   function automatic pc_pkg::pc_dec_t pc_decode(input logic [7:0] op);
      pc_pkg::pc_dec_t d;
      d = '0;
      d.kind = pc_pkg::PC_K_PLAIN;
      {d.len, d.cyc} = `PC_R1C1;
      if (op[3]) begin
         // working register column
         case (op[7:4])
            4'h7, 4'h8, 4'ha: {d.len, d.cyc} = `PC_R2C2;
            4'hb: begin
               {d.len, d.cyc} = `PC_R3C3;
               d.br = 1'b1;
            end
            4'hd: begin
               {d.len, d.cyc} = `PC_R2C2;
               d.br = 1'b1;
            end
            default: {d.len, d.cyc} = `PC_R1C1;
         endcase
      end else begin
         case (op[2:0])
            3'h6, 3'h7: begin
               case (op[7:4])
                  4'h7, 4'h8, 4'ha: {d.len, d.cyc} = `PC_R2C2;
                  4'hb: begin
                     {d.len, d.cyc} = `PC_R3C4;
                     d.br = 1'b1;
                  end
                  default: {d.len, d.cyc} = `PC_R1C2;
               endcase
            end
            3'h5: begin
               case (op[7:4])
                  4'h7, 4'h8: {d.len, d.cyc} = `PC_R3C3;
                  4'ha: {d.len, d.cyc} = `PC_R1C1;
                  4'hb, 4'hd: begin
                     {d.len, d.cyc} = `PC_R3C3;
                     d.br = 1'b1;
                  end
                  default: {d.len, d.cyc} = `PC_R2C2;
               endcase
            end
            3'h4: begin
               case (op[7:4])
                  4'h0, 4'h1, 4'hc, 4'hd, 4'he, 4'hf: {d.len, d.cyc} = `PC_R1C1;
                  4'h8: {d.len, d.cyc} = `PC_R1C8;
                  4'ha: {d.len, d.cyc} = `PC_R1C4;
                  4'hb: begin
                     {d.len, d.cyc} = `PC_R3C3;
                     d.br = 1'b1;
                  end
                  default: {d.len, d.cyc} = `PC_R2C2;
               endcase
            end
            3'h3: begin
               case (op[7:4])
                  4'h4, 4'h5, 4'h6: {d.len, d.cyc} = `PC_R3C3;
                  4'h7: {d.len, d.cyc} = `PC_R1C3;
                  4'h8, 4'h9: begin
                     {d.len, d.cyc} = `PC_R1C4;
                     d.kind = pc_pkg::PC_K_CODE_BYTE_MOVE;
                  end
                  4'he: begin
                     {d.len, d.cyc} = `PC_R1C3;
                     d.kind = pc_pkg::PC_K_XRD;
                  end
                  4'hf: begin
                     {d.len, d.cyc} = `PC_R1C3;
                     d.kind = pc_pkg::PC_K_XWR;
                  end
                  default: {d.len, d.cyc} = `PC_R1C1;
               endcase
            end
            3'h2: begin
               case (op[7:4])
                  4'h0, 4'h1: {d.len, d.cyc} = `PC_R3C4;
                  4'h2, 4'h3: {d.len, d.cyc} = `PC_R1C5;
                  4'he: begin
                     {d.len, d.cyc} = `PC_R1C3;
                     d.kind = pc_pkg::PC_K_XRD;
                  end
                  4'hf: begin
                     {d.len, d.cyc} = `PC_R1C3;
                     d.kind = pc_pkg::PC_K_XWR;
                  end
                  default: {d.len, d.cyc} = `PC_R2C2;
               endcase
            end
            3'h1: {d.len, d.cyc} = `PC_R2C3;
            default: begin
               case (op[7:4])
                  4'h0: {d.len, d.cyc} = `PC_R1C1;
                  4'h1, 4'h2, 4'h3: begin
                     {d.len, d.cyc} = `PC_R3C3;
                     d.br = 1'b1;
                  end
                  4'h4, 4'h5, 4'h6, 4'h7: begin
                     {d.len, d.cyc} = `PC_R2C2;
                     d.br = 1'b1;
                  end
                  4'h8: {d.len, d.cyc} = `PC_R2C3;
                  4'h9: {d.len, d.cyc} = `PC_R3C3;
                  4'he: begin
                     {d.len, d.cyc} = `PC_R1C3;
                     d.kind = pc_pkg::PC_K_XRD;
                  end
                  4'hf: begin
                     {d.len, d.cyc} = `PC_R1C3;
                     d.kind = pc_pkg::PC_K_XWR;
                  end
                  default: {d.len, d.cyc} = `PC_R2C2;
               endcase
            end
         endcase
      end
      return d;
   endfunction : pc_decode

   pc_pkg::pc_dec_t dec;
   pc_pkg::pc_state_t state;
   logic [4:0] cyc_sum;
   logic [3:0] cyc_eff;
   logic [3:0] cnt;
   logic [1:0] cur_len;
   logic [3:0] cur_cyc;
   logic bp_hit;
   logic stop;
   logic take;
   logic skip_bp;
   logic step_arm;
   logic halt_after;

   always_comb begin
      dec = pc_decode(issue_in.opcode);
      cyc_sum = {1'b0, dec.cyc};
      if (dec.kind == pc_pkg::PC_K_CODE_BYTE_MOVE) begin
         // flash read wait states and odd alignment stretch the fetch
         cyc_sum = `PC_CODE_BYTE_MOVE_BASE + {4'h0, issue_in.pc[`PC_ALIGN_BIT]}
                   + {3'h0, flash_read_timing_in};
         if (cyc_sum > `PC_CODE_BYTE_MOVE_MAX) begin
            cyc_sum = `PC_CODE_BYTE_MOVE_MAX;
         end
      end
      if (dec.br && issue_in.taken) begin
         cyc_sum = cyc_sum + `PC_BR_EXTRA;
      end
      // without prefetch each instruction waits one extra cycle, up to the 8-cycle cap; figures above assume it on
      if (!prefetch_enable_in) begin
         cyc_sum = cyc_sum + `PC_NOPF_EXTRA;
      end
      if (cyc_sum > `PC_MAX_CYC) begin
         cyc_sum = `PC_MAX_CYC;
      end
      cyc_eff = cyc_sum[3:0];
   end

   // breakpoint compare is a private comparator, no user resource touched
   assign bp_hit = bp_enable_in && issue_valid_in && ready_out && !skip_bp
                   && (issue_in.pc == bp_addr_in);
   assign stop = ready_out && (bp_hit || dbg_halt_in || halt_after);
   assign take = issue_valid_in && ready_out && !stop;

   // sequencer: one clock per count, no machine-cycle prescale
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         state <= pc_pkg::PC_ST_RUN;
         ready_out <= 1'b1;
         halted_out <= 1'b0;
         cnt <= `PC_CNT_ZERO;
      end else begin
         case (state)
            pc_pkg::PC_ST_RUN: begin
               if (stop) begin
                  state <= pc_pkg::PC_ST_HALT;
                  ready_out <= 1'b0;
                  halted_out <= 1'b1;
               end else if (take && cyc_eff != `PC_ONE_CYC) begin
                  state <= pc_pkg::PC_ST_EXEC;
                  ready_out <= 1'b0;
                  cnt <= cyc_eff - `PC_CNT_ONE;
               end
            end
            pc_pkg::PC_ST_EXEC: begin
               cnt <= cnt - `PC_CNT_ONE;
               if (cnt == `PC_CNT_ONE) begin
                  state <= pc_pkg::PC_ST_RUN;
                  ready_out <= 1'b1;
               end
            end
            pc_pkg::PC_ST_HALT: begin
               if (dbg_run_in || dbg_step_in) begin
                  state <= pc_pkg::PC_ST_RUN;
                  ready_out <= 1'b1;
                  halted_out <= 1'b0;
               end
            end
            default: begin
               state <= pc_pkg::PC_ST_RUN;
               ready_out <= 1'b1;
               halted_out <= 1'b0;
            end
         endcase
      end
   end

   // single step and breakpoint re-arm
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         skip_bp <= 1'b0;
         step_arm <= 1'b0;
         halt_after <= 1'b0;
      end else if (state == pc_pkg::PC_ST_HALT) begin
         halt_after <= 1'b0;
         if (dbg_step_in || dbg_run_in) begin
            skip_bp <= 1'b1; // resume past the breakpoint that stopped us
            step_arm <= dbg_step_in;
         end
      end else if (take) begin
         skip_bp <= 1'b0;
         step_arm <= 1'b0;
         halt_after <= step_arm;
      end
   end

   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         cur_len <= '0;
         cur_cyc <= '0;
      end else if (take) begin
         cur_len <= dec.len;
         cur_cyc <= cyc_eff;
      end
   end

   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         retire_out <= '0;
      end else if (take && cyc_eff == `PC_ONE_CYC) begin
         retire_out <= '{valid: 1'b1, len: dec.len, cyc: cyc_eff};
      end else if (state == pc_pkg::PC_ST_EXEC && cnt == `PC_CNT_ONE) begin
         retire_out <= '{valid: 1'b1, len: cur_len, cyc: cur_cyc};
      end else begin
         retire_out.valid <= 1'b0;
      end
   end

   // flash strobes; the write/erase enables are software controls outside
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         flash_out <= '0;
      end else begin
         flash_out.rd <= take && dec.kind == pc_pkg::PC_K_CODE_BYTE_MOVE;
         flash_out.wr <= take && dec.kind == pc_pkg::PC_K_XWR
                         && flash_write_en_in && !flash_erase_en_in;
         flash_out.erase <= take && dec.kind == pc_pkg::PC_K_XWR
                            && flash_write_en_in && flash_erase_en_in;
      end
   end

   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (!nrst_in);

   sequence s_busy1;
      !ready_out ##1 ready_out;
   endsequence
   sequence s_busy3;
      !ready_out [*3] ##1 ready_out;
   endsequence

   a_div_eight: assert property (take && issue_in.opcode == `PC_OP_DIV && prefetch_enable_in
      |=> !ready_out [*7] ##1 ready_out) else $error("divide not eight cycles");
   a_mul_four: assert property (take && issue_in.opcode == `PC_OP_MUL && prefetch_enable_in
      |=> s_busy3) else $error("multiply not four cycles");
   a_branch_taken: assert property (take && issue_in.opcode == `PC_OP_JC && issue_in.taken
      && prefetch_enable_in |=> s_busy3) else $error("taken branch not four");
   a_branch_fall: assert property (take && issue_in.opcode == `PC_OP_JC && !issue_in.taken
      && prefetch_enable_in |=> s_busy1) else $error("fallthrough not two");
   a_reg_arith: assert property (take && prefetch_enable_in
      && (issue_in.opcode[7:3] == `PC_OP_ADD_RN || issue_in.opcode[7:3] == `PC_OP_ADDC_RN
      || issue_in.opcode[7:3] == `PC_OP_SUBB_RN)
      |=> ready_out && retire_out.valid && retire_out.cyc == 4'h1 && retire_out.len == 2'h1)
      else $error("register arithmetic not single cycle");
   a_dir_arith: assert property (take && prefetch_enable_in
      && (issue_in.opcode == `PC_OP_ADD_DIR || issue_in.opcode == `PC_OP_ADDC_DIR
      || issue_in.opcode == `PC_OP_SUBB_DIR)
      |=> !ready_out ##1 (ready_out && retire_out.cyc == 4'h2 && retire_out.len == 2'h2))
      else $error("direct arithmetic not two cycles");
   a_retire_bound: assert property (retire_out.valid
      |-> retire_out.cyc >= 4'h1 && retire_out.cyc <= 4'h8)
      else $error("retired cycle count out of range");
   a_code_byte_move_range: assert property (take && dec.kind == pc_pkg::PC_K_CODE_BYTE_MOVE && prefetch_enable_in
      |-> cyc_eff >= 4'h4 && cyc_eff <= 4'h7) else $error("code move outside 4..7");
   a_bp_halt: assert property (bp_hit |=> halted_out && !ready_out && !retire_out.valid)
      else $error("breakpoint did not halt");
   a_flash_write: assert property (take && dec.kind == pc_pkg::PC_K_XWR && flash_write_en_in
      |=> flash_out.wr || flash_out.erase) else $error("flash write strobe missing");

endmodule : pc_core_timing

// file: pc_defs.svh
// timing, opcode and table-entry constants for the core timing block
`ifndef PC_DEFS_SVH
`define PC_DEFS_SVH
// table entries packed as {bytes[1:0], cycles[3:0]}
`define PC_R1C1 6'h11
`define PC_R1C2 6'h12
`define PC_R1C3 6'h13
`define PC_R1C4 6'h14
`define PC_R1C5 6'h15
`define PC_R1C8 6'h18
`define PC_R2C2 6'h22
`define PC_R2C3 6'h23
`define PC_R3C3 6'h33
`define PC_R3C4 6'h34
// cycle arithmetic, 5 bits wide; one-cycle and counter constants 4 bits
`define PC_BR_EXTRA 5'h02
`define PC_NOPF_EXTRA 5'h01
`define PC_MAX_CYC 5'h08
`define PC_CODE_BYTE_MOVE_BASE 5'h04
`define PC_CODE_BYTE_MOVE_MAX 5'h07
`define PC_ONE_CYC 4'h1
`define PC_CNT_ONE 4'h1
`define PC_CNT_ZERO 4'h0
`define PC_ALIGN_BIT 0
// opcodes named by the checks
`define PC_OP_DIV 8'h84
`define PC_OP_MUL 8'ha4
`define PC_OP_JC 8'h40
`define PC_OP_ADD_RN 5'h05
`define PC_OP_ADDC_RN 5'h07
`define PC_OP_SUBB_RN 5'h13
`define PC_OP_ADD_DIR 8'h25
`define PC_OP_ADDC_DIR 8'h35
`define PC_OP_SUBB_DIR 8'h95
`endif

// file: pc_pkg.sv
// types shared by the core timing block
package pc_pkg;
   typedef enum logic [1:0] {
      PC_K_PLAIN,
      PC_K_CODE_BYTE_MOVE,
      PC_K_XRD,
      PC_K_XWR
   } pc_kind_t;
   typedef enum logic [1:0] {
      PC_ST_RUN,
      PC_ST_EXEC,
      PC_ST_HALT
   } pc_state_t;
   typedef struct packed {
      logic [7:0] opcode;
      logic [15:0] pc;
      logic taken;
   } pc_issue_t;
   typedef struct packed {
      logic [1:0] len;
      logic [3:0] cyc;
      logic br;
      pc_kind_t kind;
   } pc_dec_t;
   typedef struct packed {
      logic valid;
      logic [1:0] len;
      logic [3:0] cyc;
   } pc_retire_t;
   typedef struct packed {
      logic rd;
      logic wr;
      logic erase;
   } pc_flash_t;
endpackage : pc_pkg

// file: pc_flash_host.sv
// far-side model: flash strobe counter and debug host driving halt/run/step and breakpoint
`timescale 1ns/1ns
module pc_flash_host (
   input wire logic clk_in,
   input wire logic nrst_in,
   input wire pc_pkg::pc_flash_t flash_in,
   output logic dbg_halt_out,
   output logic dbg_run_out,
   output logic dbg_step_out,
   output logic bp_enable_out,
   output logic [15:0] bp_addr_out
);
   int n_rd;
   int n_wr;
   int n_erase;
   initial begin
      dbg_halt_out = 1'b0;
      dbg_run_out = 1'b0;
      dbg_step_out = 1'b0;
      bp_enable_out = 1'b0;
      bp_addr_out = 16'h0000;
   end
   // one byte moves per strobe, so counting strobes counts bytes
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         n_rd <= 0;
         n_wr <= 0;
         n_erase <= 0;
      end else begin
         n_rd <= n_rd + int'(flash_in.rd);
         n_wr <= n_wr + int'(flash_in.wr);
         n_erase <= n_erase + int'(flash_in.erase);
      end
   end
   // 0 halt, 1 run, 2 step; a command stands for exactly one clock
   task automatic command(input int which);
      @(posedge clk_in);
      #1;
      dbg_halt_out = (which == 0);
      dbg_run_out = (which == 1);
      dbg_step_out = (which == 2);
      @(posedge clk_in);
      #1;
      dbg_halt_out = 1'b0;
      dbg_run_out = 1'b0;
      dbg_step_out = 1'b0;
   endtask : command
   task automatic set_break(input logic en, input logic [15:0] addr);
      @(posedge clk_in);
      #1;
      bp_enable_out = en;
      bp_addr_out = addr;
   endtask : set_break
endmodule : pc_flash_host

// file: testbench.sv
// self-checking bench for the core timing block
`timescale 1ns/1ns
module testbench;
   logic clk_in = 1'b0;
   logic nrst_in = 1'b0;
   logic issue_valid_in;
   pc_pkg::pc_issue_t issue_in;
   logic prefetch_enable_in;
   logic [1:0] flash_read_timing_in;
   logic flash_write_en_in;
   logic flash_erase_en_in;
   logic dbg_halt_in;
   logic dbg_run_in;
   logic dbg_step_in;
   logic bp_enable_in;
   logic [15:0] bp_addr_in;
   logic ready_out;
   pc_pkg::pc_retire_t retire_out;
   pc_pkg::pc_flash_t flash_out;
   logic halted_out;
   int miscompares = 0;
   int n_compared = 0;
   int cycles = 0;
   int exp_rd = 0;
   int exp_wr = 0;
   int exp_erase = 0;
   logic [7:0] sp [17] = '{8'h84, 8'ha4, 8'ha3, 8'hd4, 8'h40, 8'h50, 8'h20, 8'h30, 8'h10,
      8'h93, 8'h83, 8'he0, 8'hf0, 8'hf2, 8'h42, 8'h53, 8'h63};
   always #50 clk_in = ~clk_in;
   pc_core_timing pc_core_timing_i (.clk_in(clk_in), .nrst_in(nrst_in),
      .issue_valid_in(issue_valid_in), .issue_in(issue_in),
      .prefetch_enable_in(prefetch_enable_in), .flash_read_timing_in(flash_read_timing_in),
      .flash_write_en_in(flash_write_en_in), .flash_erase_en_in(flash_erase_en_in),
      .dbg_halt_in(dbg_halt_in), .dbg_run_in(dbg_run_in), .dbg_step_in(dbg_step_in),
      .bp_enable_in(bp_enable_in), .bp_addr_in(bp_addr_in), .ready_out(ready_out),
      .retire_out(retire_out), .flash_out(flash_out), .halted_out(halted_out));
   pc_flash_host pc_flash_host_i (.clk_in(clk_in), .nrst_in(nrst_in), .flash_in(flash_out),
      .dbg_halt_out(dbg_halt_in), .dbg_run_out(dbg_run_in), .dbg_step_out(dbg_step_in),
      .bp_enable_out(bp_enable_in), .bp_addr_out(bp_addr_in));
   task automatic complete_run();
      $display("compared %0d miscompares %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : complete_run
   always @(posedge clk_in) begin
      cycles++;
      if (cycles == 5000) begin
         miscompares++;
         complete_run();
      end
   end
   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp) begin
         miscompares++;
         $display("wrong value %s expected %0h seen %0h", what, exp, seen);
      end
   endtask : check
   function automatic logic [5:0] expect_lc(input logic [7:0] op, input logic pc0,
         input logic tk, input logic pf, input logic [1:0] frt);
      logic [1:0] len;
      logic [4:0] c;
      len = 2'h1;
      c = 5'h01;
      case (op)
         8'h84: c = 5'h08;
         8'ha4: c = 5'h04;
         8'ha3, 8'hd4: c = 5'h01;
         8'h40, 8'h50: begin
            len = 2'h2;
            c = tk ? 5'h04 : 5'h02;
         end
         8'h10, 8'h20, 8'h30: begin
            len = 2'h3;
            c = tk ? 5'h05 : 5'h03;
         end
         8'h83, 8'h93: c = 5'h04 + {4'h0, pc0} + {3'h0, frt};
         8'he0, 8'he2, 8'he3, 8'hf0, 8'hf2, 8'hf3: c = 5'h03;
         default: begin
            if (op[3])
               c = 5'h01;
            else if (op[3:1] == 3'h3)
               c = 5'h02;
            else begin
               if (op[3:0] == 4'h3)
                  len = 2'h3;
               else if (op[3:0] != 4'h4 || op[7:4] > 4'h1)
                  len = 2'h2;
               c = {3'h0, len};
            end
         end
      endcase
      if ((op == 8'h83 || op == 8'h93) && c > 5'h07)
         c = 5'h07;
      if (!pf)
         c = c + 5'h01;
      if (c > 5'h08)
         c = 5'h08;
      return {len, c[3:0]};
   endfunction : expect_lc
   // strobe order is {rd, wr, erase}
   function automatic logic [2:0] expect_fl(input logic [7:0] op, input logic we,
         input logic ee);
      if (op == 8'h83 || op == 8'h93)
         return 3'h4;
      if ((op == 8'hf0 || op == 8'hf2 || op == 8'hf3) && we)
         return ee ? 3'h1 : 3'h2;
      return 3'h0;
   endfunction : expect_fl
   // held: offer already standing; hold: keep it up for a back-to-back take
   task automatic run_op(input logic [7:0] op, input logic [15:0] pc, input logic tk,
         input logic pf, input logic [1:0] frt, input logic we, input logic ee,
         input logic held, input logic hold);
      logic [5:0] lc;
      logic [2:0] fl;
      int n;
      int k;
      lc = expect_lc(op, pc[0], tk, pf, frt);
      n = int'(lc[3:0]);
      fl = expect_fl(op, we, ee);
      exp_rd += int'(fl[2]);
      exp_wr += int'(fl[1]);
      exp_erase += int'(fl[0]);
      if (!held) begin
         @(posedge clk_in);
         #1;
         issue_in = '{opcode: op, pc: pc, taken: tk};
         prefetch_enable_in = pf;
         flash_read_timing_in = frt;
         flash_write_en_in = we;
         flash_erase_en_in = ee;
         issue_valid_in = 1'b1;
         @(negedge clk_in);
      end
      for (k = 0; k < 20 && ready_out !== 1'b1; k++)
         @(negedge clk_in);
      @(posedge clk_in);
      #1;
      if (!hold)
         issue_valid_in = 1'b0;
      for (k = 1; k <= n; k++) begin
         @(negedge clk_in);
         check("ready", {7'h00, ready_out}, {7'h00, k == n});
         check("retire", {7'h00, retire_out.valid}, {7'h00, k == n});
         check("flash", {5'h00, flash_out}, {5'h00, k == 1 ? fl : 3'h0});
      end
      check("bytes", {6'h00, retire_out.len}, {6'h00, lc[5:4]});
      check("cycles", {4'h0, retire_out.cyc}, {4'h0, lc[3:0]});
   endtask : run_op
   task automatic wait_halted(input logic exp);
      int k;
      for (k = 0; k < 4 && halted_out !== exp; k++) begin
         @(negedge clk_in);
         check("no retire", {7'h00, retire_out.valid}, 8'h00);
      end
      check("halted", {7'h00, halted_out}, {7'h00, exp});
   endtask : wait_halted
   // offer stands two edges first so a breakpoint stop has landed
   task automatic refuse(input logic [7:0] op, input logic [15:0] pc);
      @(posedge clk_in);
      #1;
      issue_in = '{opcode: op, pc: pc, taken: 1'b0};
      issue_valid_in = 1'b1;
      repeat (2) @(posedge clk_in);
      repeat (3) begin
         @(negedge clk_in);
         check("refused", {6'h00, retire_out.valid, ready_out}, 8'h00);
      end
      @(posedge clk_in);
      #1;
      issue_valid_in = 1'b0;
   endtask : refuse
   initial begin
      int i;
      logic [7:0] op;
      logic [2:0] hi;
      issue_valid_in = 1'b0;
      issue_in = '0;
      prefetch_enable_in = 1'b1;
      flash_read_timing_in = 2'h0;
      flash_write_en_in = 1'b0;
      flash_erase_en_in = 1'b0;
      void'($urandom(17));
      repeat (6) @(posedge clk_in);
      #1;
      nrst_in = 1'b1;
      run_op(8'h84, 16'h0010, 1'b0, 1'b1, 2'h0, 1'b0, 1'b0, 1'b0, 1'b1);
      run_op(8'h84, 16'h0010, 1'b0, 1'b1, 2'h0, 1'b0, 1'b0, 1'b1, 1'b0);
      run_op(8'ha4, 16'h0011, 1'b0, 1'b1, 2'h0, 1'b0, 1'b0, 1'b0, 1'b0);
      run_op(8'h28, 16'h0012, 1'b0, 1'b1, 2'h0, 1'b0, 1'b0, 1'b0, 1'b1);
      run_op(8'h28, 16'h0012, 1'b0, 1'b1, 2'h0, 1'b0, 1'b0, 1'b1, 1'b1);
      run_op(8'h28, 16'h0012, 1'b0, 1'b1, 2'h0, 1'b0, 1'b0, 1'b1, 1'b0);
      for (i = 0; i < 10; i++)
         run_op(sp[4 + i / 2], 16'h0200, 1'(i), 1'b1, 2'h0, 1'b0, 1'b0, 1'b0, 1'b0);
      for (i = 0; i < 8; i++)
         run_op(i[2] ? 8'h83 : 8'h93, 16'(i), 1'b0, 1'b1, 2'(i >> 1), 1'b0, 1'b0, 1'b0, 1'b0);
      run_op(8'h84, 16'h0020, 1'b0, 1'b0, 2'h0, 1'b0, 1'b0, 1'b0, 1'b0);
      run_op(8'h28, 16'h0021, 1'b0, 1'b0, 2'h0, 1'b0, 1'b0, 1'b0, 1'b0);
      run_op(8'hf0, 16'h0300, 1'b0, 1'b1, 2'h0, 1'b0, 1'b0, 1'b0, 1'b0);
      run_op(8'hf2, 16'h0301, 1'b0, 1'b1, 2'h0, 1'b1, 1'b0, 1'b0, 1'b0);
      run_op(8'hf3, 16'h0302, 1'b0, 1'b1, 2'h0, 1'b1, 1'b1, 1'b0, 1'b0);
      run_op(8'he0, 16'h0303, 1'b0, 1'b1, 2'h0, 1'b1, 1'b1, 1'b0, 1'b0);
      pc_flash_host_i.command(0);
      wait_halted(1'b1);
      refuse(8'h28, 16'h0100);
      pc_flash_host_i.command(1);
      wait_halted(1'b0);
      run_op(8'h28, 16'h0100, 1'b0, 1'b1, 2'h0, 1'b0, 1'b0, 1'b0, 1'b0);
      pc_flash_host_i.set_break(1'b1, 16'h0140);
      refuse(8'h25, 16'h0140);
      wait_halted(1'b1);
      pc_flash_host_i.command(1);
      wait_halted(1'b0);
      run_op(8'h25, 16'h0140, 1'b0, 1'b1, 2'h0, 1'b0, 1'b0, 1'b0, 1'b0);
      pc_flash_host_i.set_break(1'b0, 16'h0000);
      pc_flash_host_i.command(0);
      wait_halted(1'b1);
      pc_flash_host_i.command(2);
      wait_halted(1'b0);
      run_op(8'h29, 16'h0180, 1'b0, 1'b1, 2'h0, 1'b0, 1'b0, 1'b0, 1'b1);
      wait_halted(1'b1);
      @(posedge clk_in);
      #1;
      issue_valid_in = 1'b0;
      pc_flash_host_i.command(1);
      wait_halted(1'b0);
      for (i = 0; i < 80; i++) begin
         hi = 3'($urandom % 8);
         op = {hi == 3'h7 ? 4'h9 : {1'b0, hi}, 4'h4 + 4'($urandom % 12)};
         if (i % 4 == 3)
            op = sp[$urandom % 17];
         run_op(op, 16'($urandom), 1'($urandom), ($urandom % 8) != 0, 2'($urandom),
            1'($urandom), 1'($urandom), 1'b0, 1'b0);
      end
      @(negedge clk_in);
      check("reads", 8'(pc_flash_host_i.n_rd), 8'(exp_rd));
      check("writes", 8'(pc_flash_host_i.n_wr), 8'(exp_wr));
      check("erases", 8'(pc_flash_host_i.n_erase), 8'(exp_erase));
      complete_run();
   end
endmodule : testbench
